/* File: stcp_map.svh */
// Register offsets, field positions, reset values and timing counts of the 16-bit timer.
// Assumes it is included by bare name by the package and the timer module.
// What this block does
// - Control bits 7..5 pick main clock divided by 1024, 256, 64, 8 or 1.
// - Code 101 counts external clock falling edges, code 110 rising edges.
// - Clock select 111 stops the counter, which holds its value.
// - Control bits 4..3 pick mode: 00 interval toggle, 11 PWM.
// - Mode 01 captures on rising, 10 on falling capture edges; counter keeps running.
// - Writing 1 to control bit 2 clears the counter; writing 0 does nothing.
// - Control bit 1 enables the match/capture interrupt request.
// - Control bit 0 enables the overflow interrupt request.
// - Reset clears the control register to zero.
// - Interval mode match raises match interrupt, zeroes counter, keeps counting.
// - Interval mode inverts the timer output pin on every match.
// - PWM mode match does not clear counter; counter wraps FFFF to 0000.
// - PWM output low while reference <= counter, high while reference > counter.
// - PWM period equals 65536 selected counter clock ticks.
// - Capture mode copies the counter into the data register on selected edge.
// - Capture mode requests overflow on overflow and match/capture on each capture.
// - Overflow pending clears when serviced, or by software writing 0 to bit 4.
// - Both interrupts at level three, vectors DEh overflow and DCh match/capture.
// - Capture pin feeds capture logic only when port capture select bits are 00.
`ifndef STCP_MAP_SVH
`define STCP_MAP_SVH
`define STCP_CTRL_OFFSET    8'h0a
`define STCP_CTRL_RESET     8'h00
`define STCP_CLKSEL_HI      7
`define STCP_CLKSEL_LO      5
`define STCP_MODE_HI        4
`define STCP_MODE_LO        3
`define STCP_CLR_BIT        2
`define STCP_MCIE_BIT       1
`define STCP_OVIE_BIT       0
`define STCP_PND_OVF_BIT    4
`define STCP_PND_MC_BIT     5
`define STCP_IRQ_LEVEL      2'h3
`define STCP_VEC_OVF        8'hde
`define STCP_VEC_MC         8'hdc
`define STCP_DIV_W          10
`define STCP_DIV_1024_MASK  10'h3ff
`define STCP_DIV_256_MASK   10'h0ff
`define STCP_DIV_64_MASK    10'h03f
`define STCP_DIV_8_MASK     10'h007
`define STCP_CNT_ZERO       16'h0000
`define STCP_CNT_MAX        16'hffff
`define STCP_CAPSEL_PIN     2'h0
`endif

/* File: stcp_pkg.sv */
// Types shared by the timer and its pin edge detector.
// Assumes stcp_map.svh is on the include path.
package stcp_pkg;
  `include "stcp_map.svh"
  typedef enum logic [2:0] {
    STCP_CLK_D1024 = 3'b000,
    STCP_CLK_D256  = 3'b001,
    STCP_CLK_D64   = 3'b010,
    STCP_CLK_D8    = 3'b011,
    STCP_CLK_D1    = 3'b100,
    STCP_CLK_EXTF  = 3'b101,
    STCP_CLK_EXTR  = 3'b110,
    STCP_CLK_STOP  = 3'b111
  } stcp_clksel_e;
  typedef enum logic [1:0] {
    STCP_MODE_INTERVAL = 2'b00,
    STCP_MODE_CAP_RISE = 2'b01,
    STCP_MODE_CAP_FALL = 2'b10,
    STCP_MODE_PWM      = 2'b11
  } stcp_mode_e;
endpackage

/* File: stcp_edges_if.sv */
// Edge pulses from one synchronised pin to the timer core.
// Assumes one clock domain; pulses last one cycle.
interface stcp_edges_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface

/* File: stcp_pin_edge.sv */
// Three-stage pin synchroniser with rise and fall pulse output.
// Assumes an asynchronous pin and a synchronous active-high reset.
module stcp_pin_edge (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  // Pin
  input  wire logic i_pin,
  // Edge pulses
  stcp_edges_if.src edges
);
  import stcp_pkg::*;
  logic [2:0] sync;
  logic [2:0] next_sync;
  logic       stable;
  logic       next_stable;

  // A change counts only once stages two and three agree
  always_comb begin
    next_sync   = {sync[1:0], i_pin};
    next_stable = (sync[2] == sync[1]) ? sync[2] : stable;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sync   <= 3'h0;
      stable <= 1'b0;
    end else begin
      sync   <= next_sync;
      stable <= next_stable;
    end
  end

  assign edges.rise = next_stable & ~stable;
  assign edges.fall = ~next_stable & stable;
endmodule

/* File: stcp_timer.sv */
// 16-bit timer with interval, capture and PWM modes, prescaler and pending bits.
// Assumes the CPU writes its registers through strobes in this clock domain.
`include "stcp_map.svh"
module stcp_timer (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // Control register port
  input  wire logic        i_ctrl_wr,
  input  wire logic [7:0]  i_ctrl_wdata,
  output logic [7:0]       o_timer_control,
  // Reference data register port
  input  wire logic        i_ref_high_wr,
  input  wire logic        i_ref_low_wr,
  input  wire logic [7:0]  i_ref_wdata,
  output logic [7:0]       o_reference_high_byte,
  output logic [7:0]       o_reference_low_byte,
  // Counter view
  output logic [7:0]       o_count_high_byte,
  output logic [7:0]       o_count_low_byte,
  // Pending bits and their clearing
  input  wire logic        i_pnd_wr,
  input  wire logic [7:0]  i_pnd_wdata,
  input  wire logic        i_ovf_serviced,
  output logic             o_ovf_pending,
  output logic             o_mc_pending,
  // Interrupt requests
  output logic             o_overflow_irq,
  output logic             o_match_capture_irq,
  output logic [1:0]       o_irq_level,
  output logic [7:0]       o_overflow_vector,
  output logic [7:0]       o_match_capture_vector,
  // Port control and pins
  input  wire logic [1:0]  i_port_control_high_capsel,
  input  wire logic        i_capture_input_pin,
  input  wire logic        i_external_clock_pin,
  output logic             o_match_output_pin
);
  import stcp_pkg::*;

  stcp_edges_if cap_e ();
  stcp_edges_if clk_e ();

  // Synchronise both external pins before any use
  stcp_pin_edge u_cap_edge (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_capture_input_pin),
    .edges     (cap_e)
  );
  stcp_pin_edge u_clk_edge (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_external_clock_pin),
    .edges     (clk_e)
  );

  logic [7:0]              ctrl;
  logic [7:0]              next_ctrl;
  logic [`STCP_DIV_W-1:0]  div;
  logic [`STCP_DIV_W-1:0]  next_div;
  logic [15:0]             cnt;
  logic [15:0]             next_cnt;
  logic [15:0]             refv;
  logic [15:0]             next_refv;
  logic                    out_q;
  logic                    next_out_q;
  logic                    ovf_pnd;
  logic                    next_ovf_pnd;
  logic                    mc_pnd;
  logic                    next_mc_pnd;
  logic                    ovf_irq;
  logic                    next_ovf_irq;
  logic                    mc_irq;
  logic                    next_mc_irq;
  stcp_clksel_e            clksel;
  stcp_mode_e              mode;
  logic                    tick;
  logic                    match;
  logic                    ovf_ev;
  logic                    cap_ev;
  logic                    mc_ev;

  assign clksel = stcp_clksel_e'(ctrl[`STCP_CLKSEL_HI:`STCP_CLKSEL_LO]);
  assign mode   = stcp_mode_e'(ctrl[`STCP_MODE_HI:`STCP_MODE_LO]);

  // Prescaler runs free; taps give one tick per divided period
  always_comb begin
    next_div = div + `STCP_DIV_W'(1);
    case (clksel)
      STCP_CLK_D1024: tick = (div & `STCP_DIV_1024_MASK) == `STCP_DIV_1024_MASK;
      STCP_CLK_D256:  tick = (div & `STCP_DIV_256_MASK) == `STCP_DIV_256_MASK;
      STCP_CLK_D64:   tick = (div & `STCP_DIV_64_MASK) == `STCP_DIV_64_MASK;
      STCP_CLK_D8:    tick = (div & `STCP_DIV_8_MASK) == `STCP_DIV_8_MASK;
      STCP_CLK_D1:    tick = 1'b1;
      STCP_CLK_EXTF:  tick = clk_e.fall;
      STCP_CLK_EXTR:  tick = clk_e.rise;
      default:        tick = 1'b0; // Stopped counter holds
    endcase
  end

  // Compare and capture conditions
  always_comb begin
    match  = (cnt == refv) && tick &&
             (mode == STCP_MODE_INTERVAL || mode == STCP_MODE_PWM);
    ovf_ev = tick && (cnt == `STCP_CNT_MAX) && (mode != STCP_MODE_INTERVAL);
    // Capture pin is only routed when the port selects it
    cap_ev = (i_port_control_high_capsel == `STCP_CAPSEL_PIN) &&
             ((mode == STCP_MODE_CAP_RISE && cap_e.rise) ||
              (mode == STCP_MODE_CAP_FALL && cap_e.fall));
    mc_ev  = match || cap_ev;
  end

  // Counter, reference/capture data and control register
  always_comb begin
    next_ctrl = ctrl;
    next_cnt  = cnt;
    next_refv = refv;
    if (tick) begin
      if (match && mode == STCP_MODE_INTERVAL) begin
        next_cnt = `STCP_CNT_ZERO; // Restart after match
      end else begin
        next_cnt = cnt + 16'h0001; // Wraps to zero, 65536 ticks a period
      end
    end
    if (i_ctrl_wr) begin
      // Clear bit acts on write only and is never stored
      next_ctrl = i_ctrl_wdata & ~(8'h01 << `STCP_CLR_BIT);
      if (i_ctrl_wdata[`STCP_CLR_BIT]) begin
        next_cnt = `STCP_CNT_ZERO;
      end
    end
    if (i_ref_high_wr) begin
      next_refv[15:8] = i_ref_wdata;
    end
    if (i_ref_low_wr) begin
      next_refv[7:0] = i_ref_wdata;
    end
    // Capture beats a same-cycle software write to the data register
    if (cap_ev) begin
      next_refv = cnt;
    end
  end

  // Output pin: toggle in interval mode, compare level in PWM mode
  always_comb begin
    next_out_q = out_q;
    if (mode == STCP_MODE_PWM) begin
      next_out_q = (refv > next_cnt); // Low when ref <= count
    end else if (match) begin
      next_out_q = ~out_q;
    end
  end

  // Pending flags: a hardware set wins over a same-cycle clear
  always_comb begin
    next_ovf_pnd = ovf_pnd;
    next_mc_pnd  = mc_pnd;
    if (i_ovf_serviced) begin
      next_ovf_pnd = 1'b0;
    end
    if (i_pnd_wr && !i_pnd_wdata[`STCP_PND_OVF_BIT]) begin
      next_ovf_pnd = 1'b0;
    end
    // Only software clears this flag
    if (i_pnd_wr && !i_pnd_wdata[`STCP_PND_MC_BIT]) begin
      next_mc_pnd = 1'b0;
    end
    if (ovf_ev && ctrl[`STCP_OVIE_BIT]) begin
      next_ovf_pnd = 1'b1;
    end
    if (mc_ev && ctrl[`STCP_MCIE_BIT]) begin
      next_mc_pnd = 1'b1;
    end
    next_ovf_irq = next_ovf_pnd;
    next_mc_irq  = next_mc_pnd;
  end

  // State registers; reset zeroes control, selecting /1024 interval mode
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl    <= `STCP_CTRL_RESET;
      div     <= '0;
      cnt     <= `STCP_CNT_ZERO;
      refv    <= `STCP_CNT_ZERO;
      out_q   <= 1'b0;
      ovf_pnd <= 1'b0;
      mc_pnd  <= 1'b0;
      ovf_irq <= 1'b0;
      mc_irq  <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      div     <= next_div;
      cnt     <= next_cnt;
      refv    <= next_refv;
      out_q   <= next_out_q;
      ovf_pnd <= next_ovf_pnd;
      mc_pnd  <= next_mc_pnd;
      ovf_irq <= next_ovf_irq;
      mc_irq  <= next_mc_irq;
    end
  end

  // Fixed request level and vectors, registered so outputs come from flops
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_irq_level            <= 2'h0;
      o_overflow_vector      <= 8'h00;
      o_match_capture_vector <= 8'h00;
    end else begin
      o_irq_level            <= `STCP_IRQ_LEVEL;
      o_overflow_vector      <= `STCP_VEC_OVF;
      o_match_capture_vector <= `STCP_VEC_MC;
    end
  end

  assign o_timer_control       = ctrl;
  assign o_reference_high_byte = refv[15:8];
  assign o_reference_low_byte  = refv[7:0];
  assign o_count_high_byte     = cnt[15:8];
  assign o_count_low_byte      = cnt[7:0];
  assign o_ovf_pending         = ovf_pnd;
  assign o_mc_pending          = mc_pnd;
  assign o_overflow_irq        = ovf_irq;
  assign o_match_capture_irq   = mc_irq;
  assign o_match_output_pin    = out_q;
endmodule

/* File: stcp_pins.sv */
// Model of the pins around the timer: capture input and external clock.
// Assumes the bench calls its tasks just after a clock edge.
module stcp_pins (
  // Pins driven into the timer
  output logic o_cap,
  output logic o_eclk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both pins idle low; a level holds until the next call
  initial begin
    o_cap = 1'b0;
    o_eclk = 1'b0;
  end
  // One call makes one edge only when it changes the level, so the bench can count them
  task automatic set_cap(input logic v);
    o_cap = v;
  endtask
  task automatic set_eclk(input logic v);
    o_eclk = v;
  endtask
endmodule

/* File: stcp_asserts.sv */
// Port-level checks of the timer.
// Assumes one clock and a synchronous active-high reset.
module stcp_asserts (
  // Clock and reset
  input wire logic       i_mclk,
  input wire logic       i_sys_rst,
  // Strobes
  input wire logic       i_ctrl_wr,
  input wire logic [7:0] i_ctrl_wdata,
  input wire logic       i_pnd_wr,
  input wire logic [7:0] i_pnd_wdata,
  // Outputs
  input wire logic [7:0] o_timer_control,
  input wire logic [7:0] o_reference_high_byte,
  input wire logic [7:0] o_reference_low_byte,
  input wire logic [7:0] o_count_high_byte,
  input wire logic [7:0] o_count_low_byte,
  input wire logic       o_mc_pending,
  input wire logic       o_match_output_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Whole-word views, since the design only shows bytes
  wire logic [15:0] cnt = {o_count_high_byte, o_count_low_byte};
  wire logic [15:0] refv = {o_reference_high_byte, o_reference_low_byte};
  wire logic [4:0]  cfg = o_timer_control[7:3];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_rst; $past(i_sys_rst) |-> o_timer_control == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("control not cleared");
  property p_wr; i_ctrl_wr |=> o_timer_control == ($past(i_ctrl_wdata) & 8'hfb); endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_clr; i_ctrl_wr && i_ctrl_wdata[2] |=> cnt == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("counter not cleared");
  property p_stop; cfg[4:2] == 3'b111 && !i_ctrl_wr |=> $stable(cnt); endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  // Divide-by-one free run must wrap through zero
  property p_run; cfg == 5'b10011 && !i_ctrl_wr |=> cnt == $past(cnt) + 16'h0001; endproperty
  a_run: assert property (p_run) else $error("free run step wrong");
  property p_ival;
    cfg == 5'b10000 && cnt == refv && !i_ctrl_wr
      |=> cnt == 16'h0000 && o_match_output_pin != $past(o_match_output_pin);
  endproperty
  a_ival: assert property (p_ival) else $error("interval match wrong");
  // Only judged once mode and reference have settled for a cycle
  property p_pwm;
    cfg[1:0] == 2'b11 && $stable(o_timer_control) && $stable(refv)
      |-> o_match_output_pin == (refv > cnt);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level wrong");
  property p_mc; o_mc_pending && !(i_pnd_wr && !i_pnd_wdata[5]) |=> o_mc_pending; endproperty
  a_mc: assert property (p_mc) else $error("match pending dropped");
endmodule
bind stcp_timer stcp_asserts chk_u (
  .i_mclk, .i_sys_rst, .i_ctrl_wr, .i_ctrl_wdata, .i_pnd_wr, .i_pnd_wdata,
  .o_timer_control, .o_reference_high_byte, .o_reference_low_byte,
  .o_count_high_byte, .o_count_low_byte, .o_mc_pending, .o_match_output_pin
);

/* File: testbench.sv */
// Self-checking bench: register strobes, pins and pending bits of the timer.
// Assumes the design, pin model and checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  wr_s = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic [1:0]  capsel = 2'h0;
  logic        svc = 1'b0;
  logic [7:0]  ctl, rhi, rlo, chi, clo, vo, vm;
  logic [1:0]  lvl;
  logic        ovf, mc, ovf_irq, mc_irq, pin_out, cap, eclk;
  logic [15:0] a, r0;
  int          num_errors = 0, checks_done = 0, cycles = 0, t0;
  wire  [15:0] cnt = {chi, clo};
  wire  [15:0] refv = {rhi, rlo};
  // Counts per 1024 cycles for clock codes 0..4 and the stop code
  const int per_k[6] = '{1, 4, 16, 128, 1024, 0};
  stcp_timer dut_u (
    .i_mclk, .i_sys_rst(rst), .i_ctrl_wr(wr_s[3]), .i_ctrl_wdata(wdata),
    .o_timer_control(ctl), .i_ref_high_wr(wr_s[2]), .i_ref_low_wr(wr_s[1]),
    .i_ref_wdata(wdata), .o_reference_high_byte(rhi), .o_reference_low_byte(rlo),
    .o_count_high_byte(chi), .o_count_low_byte(clo), .i_pnd_wr(wr_s[0]),
    .i_pnd_wdata(wdata), .i_ovf_serviced(svc), .o_ovf_pending(ovf), .o_mc_pending(mc),
    .o_overflow_irq(ovf_irq), .o_match_capture_irq(mc_irq), .o_irq_level(lvl),
    .o_overflow_vector(vo), .o_match_capture_vector(vm),
    .i_port_control_high_capsel(capsel), .i_capture_input_pin(cap),
    .i_external_clock_pin(eclk), .o_match_output_pin(pin_out)
  );
  stcp_pins pins_u (.o_cap(cap), .o_eclk(eclk));
  always #50 i_mclk = ~i_mclk;
  // Hang guard; the full run needs about 72000 cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #10;
  endtask
  // k: 0 control, 1 ref high, 2 ref low, 3 pending; idle cycle after each strobe
  task automatic wr(input int k, input logic [7:0] d);
    wdata = d;
    wr_s = 4'h8 >> k;
    tick(1);
    wr_s = 4'h0;
    tick(1);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(4);
    rst = 1'b0;
    tick(2);
    chk(ctl, 16'h0000);
    chk(lvl, 16'h0003);
    chk({vo, vm}, 16'hdedc);
    // Reference at top so interval mode never matches while rates are measured
    wr(1, 8'hff);
    wr(2, 8'hff);
    for (int c = 0; c < 6; c++) begin
      wr(0, {(c == 5) ? 3'h7 : c[2:0], 5'b00100});
      a = cnt;
      tick(1024);
      chk(cnt - a, 16'(per_k[c]));
    end
    wr(1, 8'h00);
    wr(2, 8'h10);
    wr(0, 8'h86);
    tick(20);
    a = {15'h0, pin_out};
    tick(17);
    chk(pin_out, !a[0]);
    chk(mc, 16'h0001);
    // Matches go on but can no longer set the flag, so only a write could drop it
    wr(0, 8'h80);
    wr(3, 8'hff);
    chk(mc, 16'h0001);
    wr(3, 8'hdf);
    tick(40);
    chk(mc, 16'h0000);
    for (int c = 5; c < 7; c++) begin
      wr(0, {c[2:0], 5'b00100});
      a = cnt;
      pins_u.set_eclk(1'b1);
      tick(6);
      chk(cnt - a, 16'(c - 5));
      pins_u.set_eclk(1'b0);
      tick(6);
      chk(cnt - a, 16'h0001);
    end
    capsel = 2'h1;
    wr(0, 8'h8e);
    a = refv;
    pins_u.set_cap(1'b1);
    tick(8);
    chk(refv, a);
    capsel = 2'h0;
    for (int m = 1; m < 3; m++) begin
      wr(0, {3'b100, m[1:0], 3'b110});
      wr(3, 8'hdf);
      for (int k = 0; k < 2; k++) begin
        r0 = refv;
        a = cnt;
        pins_u.set_cap(!cap);
        tick(8);
        if (cap == (m == 1)) begin
          // Three synchroniser stages put the captured count three ticks on
          chk(refv - a, 16'h0003);
          chk(mc, 16'h0001);
        end else begin
          chk(refv, r0);
        end
      end
    end
    wr(1, 8'h80);
    wr(2, 8'h00);
    wr(0, 8'h9f);
    t0 = cycles;
    wr(3, 8'hdf);
    chk(pin_out, 16'h0001);
    tick(32800);
    chk(pin_out, 16'h0000);
    chk({mc, ovf}, 16'h0002);
    for (int i = 0; i < 40000 && ovf !== 1'b1; i++) tick(1);
    chk(ovf, 16'h0001);
    // t0 is one edge after the clearing write, so a 65536-tick lap shows as 65535
    chk(16'(cycles - t0), 16'hffff);
    chk(pin_out, 16'h0001);
    svc = 1'b1;
    tick(1);
    svc = 1'b0;
    tick(1);
    chk({ovf, ovf_irq, mc_irq}, 16'h0001);
    print_verdict();
  end
endmodule
